// ===== pkg/prox_event_pkg.sv
// Purpose: shared constants and types of the proximity event block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: byte offsets are fixed here only
package prox_event_pkg;
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_FAR_THR = 8'h04;
	localparam logic [7:0] OFS_NEAR_THR = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// config word: bit0 detect_output_select, bits 2:1 persistence_count-1
	localparam int CFG_MODE_BIT = 0;
	localparam int CFG_PERS_LSB = 1;
	// flag word: bit1 approach_flag, bit0 departure_flag
	localparam int FLAG_APPROACH_BIT = 1;
	localparam int FLAG_DEPARTURE_BIT = 0;
	localparam logic [15:0] NEAR_THR_RESET = 16'h0000;
	localparam logic [15:0] FAR_THR_RESET = 16'h0000;
	localparam logic [2:0] PERS_MAX = 3'h4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic detect_output_select;
		logic [1:0] persistence_count;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{detect_output_select: 1'b0, persistence_count: 2'h0};

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
	} wr_pend_t;
endpackage

// ===== hw/proximity_event_output.sv
// Purpose: threshold compare, persistence, flags and event/detect pin
// Assumes: count samples arrive on hclk from the measurement logic
// Notes: zero-wait AHB-Lite slave, flag register clears on read
// Behaviour
// - register selects detect-output or interrupt pin mode
// - detect mode: pin low when near
// - detect mode: pin high again when far
// - programmed thresholds decide near and far
// - counts between thresholds keep state unchanged
// - interrupt mode: flag holds until register cleared
// - reading flag register clears its flags
// - set flags block new events until cleared
// - interrupt mode: approach raised when count exceeds near threshold
// - approach and departure flags in flag register
// - interrupt mode: any flag set drives pin low; read releases unless a same-cycle event sets a flag
// - persistence of one to four consecutive samples
`timescale 1ns/1ps
module proximity_event_output
	import prox_event_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [COUNT_W-1:0] prox_count,
	input wire logic prox_valid,
	output logic event_or_detect_pin_n
);
	////////////////////////////////////////////////////////////////////
	function automatic logic [2:0] sat_inc(input logic [2:0] c);
		sat_inc = (c == PERS_MAX) ? PERS_MAX : c + 3'h1;
	endfunction

	cfg_t cfg_reg, cfg_next;
	logic [COUNT_W-1:0] near_thr_reg, near_thr_next, far_thr_reg, far_thr_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [2:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
	logic near_reg, near_next;
	logic [1:0] flags_reg, flags_next;
	logic pin_n_reg, pin_n_next;
	wr_pend_t wr_reg, wr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic access, rd_clr, above, below, hit_hi, hit_lo, accept;
	logic [1:0] new_ev;
	logic [2:0] need;

	assign access = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign rd_clr = access && !hwrite && (haddr == OFS_FLAGS);
	assign above = prox_count > near_thr_reg;
	assign below = prox_count < far_thr_reg;
	assign need = {1'b0, cfg_reg.persistence_count} + 3'h1;

	////////////////////////////////////////////////////////////////////
	// register bus
	always_comb begin
		wr_next.valid = access && hwrite;
		wr_next.addr = haddr;
		cfg_next = cfg_reg;
		near_thr_next = near_thr_reg;
		far_thr_next = far_thr_reg;
		if (wr_reg.valid) begin
			case (wr_reg.addr)
				OFS_CONFIG: begin
					cfg_next.detect_output_select = hwdata[CFG_MODE_BIT];
					cfg_next.persistence_count = hwdata[CFG_PERS_LSB +: 2];
				end
				OFS_FAR_THR: far_thr_next = hwdata[COUNT_W-1:0];
				OFS_NEAR_THR: near_thr_next = hwdata[COUNT_W-1:0];
				default: ;
			endcase
		end
		rdata_next = 32'h0000_0000;
		if (access && !hwrite) begin
			case (haddr)
				OFS_CONFIG: rdata_next = {29'h0, cfg_reg.persistence_count, cfg_reg.detect_output_select};
				OFS_FAR_THR: rdata_next = 32'(far_thr_reg);
				OFS_NEAR_THR: rdata_next = 32'(near_thr_reg);
				OFS_COUNT: rdata_next = 32'(count_reg);
				OFS_FLAGS: rdata_next = {30'h0, flags_reg};
				OFS_STATUS: rdata_next = {30'h0, !pin_n_reg, near_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= '0;
			cfg_reg <= CFG_RESET;
			near_thr_reg <= NEAR_THR_RESET[COUNT_W-1:0];
			far_thr_reg <= FAR_THR_RESET[COUNT_W-1:0];
			rdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			wr_reg <= wr_next;
			cfg_reg <= cfg_next;
			near_thr_reg <= near_thr_next;
			far_thr_reg <= far_thr_next;
			rdata_reg <= rdata_next;
		end
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	////////////////////////////////////////////////////////////////////
	// detection, persistence, flags, pin
	always_comb begin
		count_next = prox_valid ? prox_count : count_reg;
		hi_cnt_next = hi_cnt_reg;
		lo_cnt_next = lo_cnt_reg;
		hit_hi = 1'b0;
		hit_lo = 1'b0;
		if (prox_valid) begin
			hi_cnt_next = above ? sat_inc(hi_cnt_reg) : 3'h0;
			lo_cnt_next = below ? sat_inc(lo_cnt_reg) : 3'h0;
			hit_hi = above && (hi_cnt_next >= need);
			hit_lo = below && (lo_cnt_next >= need);
		end
		// between the thresholds neither hit fires, so state holds
		near_next = hit_hi ? 1'b1 : (hit_lo ? 1'b0 : near_reg);
		new_ev = 2'b00;
		new_ev[FLAG_APPROACH_BIT] = near_next && !near_reg;
		new_ev[FLAG_DEPARTURE_BIT] = !near_next && near_reg;
		// the read that clears also reopens the gate, so a same-cycle event is kept
		accept = !cfg_reg.detect_output_select && ((flags_reg == 2'b00) || rd_clr);
		flags_next = (rd_clr ? 2'b00 : flags_reg) | (accept ? new_ev : 2'b00);
		if (cfg_next.detect_output_select)
			pin_n_next = !near_next;
		else
			pin_n_next = !(|flags_next);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= '0;
			hi_cnt_reg <= 3'h0;
			lo_cnt_reg <= 3'h0;
			near_reg <= 1'b0;
			flags_reg <= 2'b00;
			pin_n_reg <= 1'b1;
		end else if (ce) begin
			count_reg <= count_next;
			hi_cnt_reg <= hi_cnt_next;
			lo_cnt_reg <= lo_cnt_next;
			near_reg <= near_next;
			flags_reg <= flags_next;
			pin_n_reg <= pin_n_next;
		end
	end

	assign event_or_detect_pin_n = pin_n_reg;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_detect_pin;
		cfg_reg.detect_output_select |-> (pin_n_reg == !near_reg);
	endproperty
	a_detect_pin: assert property (p_detect_pin) else $error("detect pin differs from state");

	property p_release;
		ce && cfg_next.detect_output_select && near_reg && hit_lo && !hit_hi |=> pin_n_reg && !near_reg;
	endproperty
	a_release: assert property (p_release) else $error("pin not released when far");

	property p_between;
		ce && prox_valid && !above && !below |=> $stable(near_reg);
	endproperty
	a_between: assert property (p_between) else $error("state moved between thresholds");

	property p_approach;
		ce && prox_valid && above && cfg_reg.persistence_count == 2'h0 |=> near_reg;
	endproperty
	a_approach: assert property (p_approach) else $error("no approach above threshold");

	property p_hold;
		ce && (|flags_reg) && !rd_clr |=> flags_reg == $past(flags_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("flags changed while pending");

	property p_clear;
		ce && rd_clr && new_ev == 2'b00 |=> flags_reg == 2'b00;
	endproperty
	a_clear: assert property (p_clear) else $error("read did not clear flags");

	property p_flag_set;
		ce && flags_reg == 2'b00 && !cfg_reg.detect_output_select && !near_reg && hit_hi
			|=> flags_reg[FLAG_APPROACH_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("approach flag not set");

	property p_int_pin;
		!cfg_reg.detect_output_select |-> (pin_n_reg == !(|flags_reg));
	endproperty
	a_int_pin: assert property (p_int_pin) else $error("event pin differs from flags");

	// the first exceeding sample of a fresh run must not decide near when more than one is asked for
	property p_pers;
		ce && prox_valid && above && !near_reg && hi_cnt_reg == 3'h0 && cfg_reg.persistence_count != 2'h0
			|=> !near_reg;
	endproperty
	a_pers: assert property (p_pers) else $error("event before persistence met");

	property p_departure;
		ce && flags_reg == 2'b00 && !cfg_reg.detect_output_select && near_reg && hit_lo && !hit_hi
			|=> flags_reg[FLAG_DEPARTURE_BIT];
	endproperty
	a_departure: assert property (p_departure) else $error("departure flag not set");

	property p_detect_quiet;
		ce && cfg_reg.detect_output_select && flags_reg == 2'b00 |=> flags_reg == 2'b00;
	endproperty
	a_detect_quiet: assert property (p_detect_quiet) else $error("flag set in detect mode");
endmodule

// ===== testbench/host_event_watch.sv
// Purpose: host side of the event pin
// Assumes: pin is active low and seen on hclk
// Notes: counts pin assertions the host must serve
`timescale 1ns/1ps
module host_event_watch (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic event_or_detect_pin_n,
	output logic [7:0] fall_count
);
	logic pin_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_reg <= 1'b1;
			fall_count <= 8'h00;
		end else begin
			pin_reg <= event_or_detect_pin_n;
			// each falling edge counts once; in interrupt mode it asks the host for one clearing read of the flags
			if (pin_reg && !event_or_detect_pin_n) fall_count <= fall_count + 8'h01;
		end
	end
endmodule

// ===== testbench/test_proximity_event_output.sv
// Purpose: self-checking bench of the event and detect pin block
// Assumes: zero-wait slave, one sample per prox_valid pulse
// Notes: thresholds far 0x10, near 0x20
`timescale 1ns/1ps
module test_proximity_event_output;
	import prox_event_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic prox_valid = 1'b0;
	logic ce = 1'b1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [15:0] prox_count = 16'h0;
	wire logic hreadyout;
	wire logic hresp;
	wire logic pin_n;
	wire logic [31:0] hrdata;
	wire logic [7:0] falls;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	initial forever #5 hclk = ~hclk;
	proximity_event_output dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prox_count(prox_count), .prox_valid(prox_valid),
		.event_or_detect_pin_n(pin_n));
	host_event_watch host_u (.hclk(hclk), .hresetn(hresetn), .event_or_detect_pin_n(pin_n), .fall_count(falls));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_ready;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		wait_ready;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready;
		rd = hrdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic sample(input logic [15:0] v);
		prox_count <= v;
		prox_valid <= 1'b1;
		@(posedge hclk);
		prox_valid <= 1'b0;
		// one quiet edge, so a pin read after the call sees the settled level
		@(posedge hclk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pin", 32'(pin_n), 32'h1);
		rchk("status", OFS_STATUS, 32'h0);
		rchk("flags", OFS_FLAGS, 32'h0);
		bus(1'b1, OFS_FAR_THR, 32'h10);
		bus(1'b1, OFS_NEAR_THR, 32'h20);
		rchk("near_threshold", OFS_NEAR_THR, 32'h20);
		rchk("far_threshold", OFS_FAR_THR, 32'h10);
		rchk("unmapped", 8'h1c, 32'h0);
		sample(16'h20);
		chk("pin", 32'(pin_n), 32'h1);
		rchk("count", OFS_COUNT, 32'h20);
		sample(16'h21);
		chk("pin", 32'(pin_n), 32'h0);
		sample(16'h05);
		chk("pin", 32'(pin_n), 32'h0);
		rchk("flags", OFS_FLAGS, 32'h2);
		chk("hresp", 32'(hresp), 32'h0);
		chk("pin", 32'(pin_n), 32'h1);
		rchk("flags", OFS_FLAGS, 32'h0);
		sample(16'h18);
		rchk("status", OFS_STATUS, 32'h0);
		// three samples; the in-between count restarts the run
		bus(1'b1, OFS_CONFIG, 32'h4);
		rchk("config", OFS_CONFIG, 32'h4);
		sample(16'h21);
		sample(16'h21);
		sample(16'h18);
		sample(16'h21);
		sample(16'h21);
		chk("pin", 32'(pin_n), 32'h1);
		sample(16'h21);
		chk("pin", 32'(pin_n), 32'h0);
		rchk("status", OFS_STATUS, 32'h3);
		rchk("flags", OFS_FLAGS, 32'h2);
		repeat (3) sample(16'h05);
		rchk("flags", OFS_FLAGS, 32'h1);
		bus(1'b1, OFS_CONFIG, 32'h1);
		sample(16'h21);
		chk("pin", 32'(pin_n), 32'h0);
		sample(16'h18);
		chk("pin", 32'(pin_n), 32'h0);
		rchk("flags", OFS_FLAGS, 32'h0);
		// with the clock enable low the far sample must not be taken
		ce <= 1'b0;
		sample(16'h05);
		chk("pin", 32'(pin_n), 32'h0);
		ce <= 1'b1;
		rchk("count", OFS_COUNT, 32'h18);
		sample(16'h05);
		chk("pin", 32'(pin_n), 32'h1);
		chk("host events", 32'(falls), 32'h4);
		// reset in mid-run while the detect pin is held low
		sample(16'h21);
		hresetn <= 1'b0;
		@(posedge hclk);
		chk("pin", 32'(pin_n), 32'h1);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("config", OFS_CONFIG, 32'h0);
		rchk("status", OFS_STATUS, 32'h0);
		rchk("flags", OFS_FLAGS, 32'h0);
		rchk("near_threshold", OFS_NEAR_THR, 32'h0);
		chk("pin", 32'(pin_n), 32'h1);
		final_report;
	end
endmodule
